// ### rtl/edo_defs.svh
// constants for the event output select block
`ifndef EDO_DEFS_SVH
`define EDO_DEFS_SVH

// ***************************************
// clock and counter sizing
// ***************************************
`define EDO_CLK_PERIOD_NS 5
`define EDO_CNT_W 20

// ***************************************
// reset values
// ***************************************
`define EDO_SEL_RST 4'h0

// ***************************************
// times in ns, as printed
// ***************************************
`define EDO_T_BOOT_NS 1390000
`define EDO_T_RW_ON_NS 3500000
`define EDO_T_WR_OFF_NS 3930000
`define EDO_T_RD_OFF_NS 2320000
`define EDO_T_ANY_ON_NS 10000
`define EDO_T_ANY_OFF_NS 160000

// ***************************************
// cycle counts, rounded up
// ***************************************
`define EDO_CYC(t) (((t) + `EDO_CLK_PERIOD_NS - 1) / `EDO_CLK_PERIOD_NS)
`define EDO_CYC_BOOT `EDO_CYC(`EDO_T_BOOT_NS)
`define EDO_CYC_RW_ON `EDO_CYC(`EDO_T_RW_ON_NS)
`define EDO_CYC_WR_OFF `EDO_CYC(`EDO_T_WR_OFF_NS)
`define EDO_CYC_RD_OFF `EDO_CYC(`EDO_T_RD_OFF_NS)
`define EDO_CYC_ANY_ON `EDO_CYC(`EDO_T_ANY_ON_NS)
`define EDO_CYC_ANY_OFF `EDO_CYC(`EDO_T_ANY_OFF_NS)

`endif

// ### rtl/edo_pkg.sv
// types for the event output select block
package edo_pkg;

   typedef logic [3:0] edo_sel_t;

   typedef enum logic [3:0] {
      EDO_SEL_STANDBY = 4'h7,
      EDO_SEL_WRITE = 4'h8,
      EDO_SEL_READ = 4'h9,
      EDO_SEL_ANY = 4'hA,
      EDO_SEL_SYNC_RD = 4'hB,
      EDO_SEL_SYNC_WR = 4'hC,
      EDO_SEL_SOFT = 4'hD
   } edo_sel_e;

   typedef enum logic [1:0] {
      EDO_ST_IDLE = 2'b00,
      EDO_ST_WAIT_ON = 2'b01,
      EDO_ST_ACTIVE = 2'b10,
      EDO_ST_WAIT_OFF = 2'b11
   } edo_state_e;

endpackage

// ### rtl/edo_delay_timer.sv
// one-shot down counter that flags the end of a programmed delay
`timescale 1ns/10ps
`include "edo_defs.svh"

module edo_delay_timer (
   input wire logic clk,
   input wire logic reset,
   input wire logic start,
   input wire logic cancel,
   input wire logic [`EDO_CNT_W-1:0] load_value,
   output logic done
);

   logic [`EDO_CNT_W-1:0] cnt_reg;
   logic [`EDO_CNT_W-1:0] cnt_next;

   // cancel beats start, so a field loss never leaves a delay running
   always_comb begin
      cnt_next = cnt_reg;
      if (cancel) begin
         cnt_next = '0;
      end else if (start) begin
         cnt_next = load_value;
      end else if (cnt_reg != '0) begin
         cnt_next = cnt_reg - `EDO_CNT_W'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   assign done = (cnt_reg == `EDO_CNT_W'(1)) && !cancel && !start;

endmodule

// ### rtl/edo_event_output.sv
// event output pin source selection and timing
`timescale 1ns/10ps
`include "edo_defs.svh"

// Behaviour
// - open-drain active-low pin, low means asserted
// - 0111: asserted while not in standby
// - standby indication follows supply by 1.39 ms
// - 1000: write start asserts, response end releases
// - write: on 3.5 ms after SOF, off 3.93 ms later
// - 1001: read start asserts, response end releases
// - read: on 3.5 ms after SOF, off 2.32 ms later
// - 1010: any SOF asserts, the delay after EOF releases
// - any command: on 10 us after SOF
// - any command: off 160 us after EOF
// - 1011: sync block read event held
// - sync read asserts at last byte before CRC
// - 1100: sync block write event held
// - clear bit 0 releases a held event
// - writing 1101 raises a software event
// - software event ignores field loss
module edo_event_output #(
   parameter logic [`EDO_CNT_W-1:0] P_CYC_BOOT = `EDO_CNT_W'(`EDO_CYC_BOOT),
   parameter logic [`EDO_CNT_W-1:0] P_CYC_RW_ON = `EDO_CNT_W'(`EDO_CYC_RW_ON),
   parameter logic [`EDO_CNT_W-1:0] P_CYC_WR_OFF = `EDO_CNT_W'(`EDO_CYC_WR_OFF),
   parameter logic [`EDO_CNT_W-1:0] P_CYC_RD_OFF = `EDO_CNT_W'(`EDO_CYC_RD_OFF),
   parameter logic [`EDO_CNT_W-1:0] P_CYC_ANY_OFF = `EDO_CNT_W'(`EDO_CYC_ANY_OFF)
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic supply_present,
   input wire logic rf_field_present,
   input wire logic standby_active,
   input wire logic frame_sof,
   input wire logic frame_eof,
   input wire logic cmd_is_write,
   input wire logic cmd_is_read,
   input wire logic response_end,
   input wire logic sync_read_last_byte,
   input wire logic sync_write_done,
   input wire logic select_write,
   input wire edo_pkg::edo_sel_t select_data,
   input wire logic clear_write,
   input wire logic [7:0] clear_data,
   input wire logic event_pin_in,
   output logic event_pin_out,
   output logic event_pin_oe_n,
   output edo_pkg::edo_sel_t event_source_select
);
   import edo_pkg::*;

   localparam logic [`EDO_CNT_W-1:0] CYC_ANY_ON = `EDO_CNT_W'(`EDO_CYC_ANY_ON);

   // ***************************************
   // pin synchronisers
   // ***************************************
   logic supply_meta_reg;
   logic supply_sync_reg;
   logic field_meta_reg;
   logic field_sync_reg;
   logic supply_prev_reg;
   logic field_prev_reg;

   always_ff @(posedge clk) begin
      if (reset) begin
         supply_meta_reg <= 1'b0;
         supply_sync_reg <= 1'b0;
         field_meta_reg <= 1'b0;
         field_sync_reg <= 1'b0;
         supply_prev_reg <= 1'b0;
         field_prev_reg <= 1'b0;
      end else begin
         supply_meta_reg <= supply_present;
         supply_sync_reg <= supply_meta_reg;
         field_meta_reg <= rf_field_present;
         field_sync_reg <= field_meta_reg;
         supply_prev_reg <= supply_sync_reg;
         field_prev_reg <= field_sync_reg;
      end
   end

   wire supply_rise = supply_sync_reg && !supply_prev_reg;
   wire field_fall = !field_sync_reg && field_prev_reg;
   wire field_off = !field_sync_reg;

   // ***************************************
   // selector and decode
   // ***************************************
   edo_sel_t sel_reg;
   wire sel_change = select_write && (select_data != sel_reg);
   wire clear_hit = clear_write && clear_data[0];

   wire mode_standby = (sel_reg == EDO_SEL_STANDBY);
   wire mode_write = (sel_reg == EDO_SEL_WRITE);
   wire mode_read = (sel_reg == EDO_SEL_READ);
   wire mode_any = (sel_reg == EDO_SEL_ANY);
   wire mode_sync_rd = (sel_reg == EDO_SEL_SYNC_RD);
   wire mode_sync_wr = (sel_reg == EDO_SEL_SYNC_WR);
   wire mode_soft = (sel_reg == EDO_SEL_SOFT);
   wire mode_rw = mode_write || mode_read;
   wire mode_timed = mode_rw || mode_any;

   always_ff @(posedge clk) begin
      if (reset) begin
         sel_reg <= `EDO_SEL_RST;
      end else if (select_write) begin
         sel_reg <= select_data;
      end
   end

   // ***************************************
   // supply boot delay
   // ***************************************
   logic boot_done;
   logic supply_ready_reg;

   edo_delay_timer u_boot_tmr (
      .clk(clk),
      .reset(reset),
      .start(supply_rise),
      .cancel(!supply_sync_reg),
      .load_value(P_CYC_BOOT),
      .done(boot_done)
   );

   always_ff @(posedge clk) begin
      if (reset || !supply_sync_reg) begin
         supply_ready_reg <= 1'b0;
      end else if (boot_done) begin
         supply_ready_reg <= 1'b1;
      end
   end

   wire standby_src = supply_ready_reg && !standby_active;

   // ***************************************
   // frame timed sequence
   // ***************************************
   edo_state_e state_reg;
   edo_state_e state_next;
   logic on_done;
   logic off_done;
   logic on_start;
   logic off_start;

   wire seq_abort = field_off || sel_change || !mode_timed;
   wire sof_hit = frame_sof && ((mode_write && cmd_is_write) || (mode_read && cmd_is_read) || mode_any);

   wire [`EDO_CNT_W-1:0] on_load = mode_any ? CYC_ANY_ON : P_CYC_RW_ON;
   wire [`EDO_CNT_W-1:0] off_load = mode_write ? P_CYC_WR_OFF : (mode_read ? P_CYC_RD_OFF : P_CYC_ANY_OFF);

   edo_delay_timer u_on_tmr (
      .clk(clk),
      .reset(reset),
      .start(on_start),
      .cancel(seq_abort),
      .load_value(on_load),
      .done(on_done)
   );

   edo_delay_timer u_off_tmr (
      .clk(clk),
      .reset(reset),
      .start(off_start),
      .cancel(seq_abort),
      .load_value(off_load),
      .done(off_done)
   );

   always_comb begin
      state_next = state_reg;
      on_start = 1'b0;
      off_start = 1'b0;
      case (state_reg)
         EDO_ST_IDLE: begin
            // a frame start that matches the selected mode arms the assert delay
            if (sof_hit) begin
               on_start = 1'b1;
               state_next = EDO_ST_WAIT_ON;
            end
         end
         EDO_ST_WAIT_ON: begin
            if (on_done && mode_any) begin
               state_next = EDO_ST_ACTIVE;
            end else if (on_done) begin
               // write and read arm the release delay
               off_start = 1'b1;
               state_next = EDO_ST_WAIT_OFF;
            end
         end
         EDO_ST_ACTIVE: begin
            // end of frame arms the release delay
            if (frame_eof) begin
               off_start = 1'b1;
               state_next = EDO_ST_WAIT_OFF;
            end
         end
         EDO_ST_WAIT_OFF: begin
            if (off_done || (mode_rw && response_end)) begin
               state_next = EDO_ST_IDLE;
            end
         end
         default: begin
            state_next = EDO_ST_IDLE;
         end
      endcase
   end

   // field loss or a new selection drops the sequence
   always_ff @(posedge clk) begin
      if (reset || seq_abort) begin
         state_reg <= EDO_ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   wire timed_src = (state_reg == EDO_ST_ACTIVE) || (state_reg == EDO_ST_WAIT_OFF);

   // ***************************************
   // held events
   // ***************************************
   logic sync_flag_reg;
   logic soft_flag_reg;

   wire sync_set = (mode_sync_rd && sync_read_last_byte) || (mode_sync_wr && sync_write_done);
   wire sync_drop = clear_hit || field_off || sel_change;

   // sticky until clear, field loss or a new selection; a set wins
   always_ff @(posedge clk) begin
      if (reset) begin
         sync_flag_reg <= 1'b0;
      end else if (sync_set) begin
         sync_flag_reg <= 1'b1;
      end else if (sync_drop) begin
         sync_flag_reg <= 1'b0;
      end
   end

   // writing the software code raises the event
   wire soft_set = select_write && (select_data == EDO_SEL_SOFT);

   // only the clear bit ends it, never the field
   always_ff @(posedge clk) begin
      if (reset) begin
         soft_flag_reg <= 1'b0;
      end else if (soft_set) begin
         soft_flag_reg <= 1'b1;
      end else if (clear_hit) begin
         soft_flag_reg <= 1'b0;
      end
   end

   // ***************************************
   // source select and pin
   // ***************************************
   // one source per code, others released
   wire src_active = (mode_standby && standby_src) || (mode_timed && timed_src)
                   || ((mode_sync_rd || mode_sync_wr) && sync_flag_reg) || (mode_soft && soft_flag_reg);

   // pin only ever pulls low; the pull-up makes high
   always_ff @(posedge clk) begin
      if (reset) begin
         event_pin_out <= 1'b0;
         event_pin_oe_n <= 1'b1;
      end else begin
         event_pin_out <= 1'b0;
         event_pin_oe_n <= !src_active;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         event_source_select <= `EDO_SEL_RST;
      end else begin
         event_source_select <= sel_reg;
      end
   end

   // ***************************************
   // checks
   // ***************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence s_sync_held;
      sync_flag_reg && !clear_hit && !field_off && !sel_change;
   endsequence

   sequence s_pin_released;
      event_pin_oe_n ##1 event_pin_oe_n;
   endsequence

   chk_pin_drives_low: assert property (event_pin_out == 1'b0)
      else $error("event pin drives a high level");

   chk_undef_released: assert property (
      !(mode_standby || mode_timed || mode_sync_rd || mode_sync_wr || mode_soft) && !select_write
      |=> ##1 event_pin_oe_n)
      else $error("undefined selector code drives the pin");

   chk_standby_level: assert property (
      mode_standby && !select_write && supply_ready_reg && !standby_active |=> !event_pin_oe_n)
      else $error("standby indication not asserted");

   chk_boot_delay: assert property (
      $rose(supply_ready_reg) |-> $past(boot_done) && $past(supply_sync_reg, 2))
      else $error("supply ready without boot delay");

   chk_write_field: assert property (
      mode_write && field_off && !select_write |=> ##1 s_pin_released)
      else $error("write indication survives field loss");

   chk_any_assert: assert property (
      (state_reg == EDO_ST_WAIT_ON) && on_done && mode_any && !seq_abort |=> ##1 !event_pin_oe_n)
      else $error("any command not asserted after delay");

   chk_rw_release: assert property (
      (state_reg == EDO_ST_WAIT_OFF) && mode_rw && response_end && !select_write && !sof_hit
      |=> (state_reg == EDO_ST_IDLE) ##1 event_pin_oe_n)
      else $error("read or write not released at response end");

   chk_sync_hold: assert property (s_sync_held |=> sync_flag_reg)
      else $error("sync event dropped without cause");

   chk_set_wins: assert property (sync_set |=> sync_flag_reg)
      else $error("sync event lost against a clear");

   chk_clear_release: assert property (
      mode_sync_rd && clear_hit && !sync_set && !select_write |=> !sync_flag_reg ##1 event_pin_oe_n)
      else $error("clear did not release the held event");

   chk_soft_field: assert property (
      soft_flag_reg && !clear_hit && field_fall |=> soft_flag_reg)
      else $error("software event dropped by field loss");

   chk_soft_raise: assert property (soft_set |=> soft_flag_reg ##1 !event_pin_oe_n)
      else $error("software event not raised");

endmodule

// ### bench/edo_pin_model.sv
// open-drain event pin with its pull-up, as the host sees it
`timescale 1ns/10ps

module edo_pin_model (
   input wire logic pin_out,
   input wire logic pin_oe_n,
   output logic pin_level
);
   // ***************************************
   // wire level
   // ***************************************
   // released pin pulled high
   assign pin_level = pin_oe_n ? 1'b1 : pin_out;
endmodule

// ### bench/tb_event_detect_output_select.sv
// self-checking bench for the event output select block
`timescale 1ns/10ps
`include "edo_defs.svh"

module tb_event_detect_output_select;
   import edo_pkg::*;
   // ***************************************
   // shortened counts; C_ANY_ON stays the full 10 us count
   // ***************************************
   localparam int C_BOOT = 40;
   localparam int C_RW_ON = 50;
   localparam int C_WR_OFF = 45;
   localparam int C_RD_OFF = 30;
   localparam int C_ANY_OFF = 32;
   localparam int C_ANY_ON = 2000;
   // edges are taken on a small window, latencies are approximate
   localparam int C_TOL = 5;
   localparam int C_LIMIT = 20000;
   localparam int P_SOF = 0;
   localparam int P_EOF = 1;
   localparam int P_RESP = 2;
   localparam int P_SRD = 3;
   localparam int P_SWR = 4;
   localparam int P_CLR = 5;
   typedef struct {logic lvl; int at;} edo_note_s;
   logic clk;
   logic reset = 1'b1;
   logic supply_present = 1'b0;
   logic rf_field_present = 1'b0;
   logic standby_active = 1'b0;
   logic frame_sof = 1'b0;
   logic frame_eof = 1'b0;
   logic cmd_is_write = 1'b0;
   logic cmd_is_read = 1'b0;
   logic response_end = 1'b0;
   logic sync_read_last_byte = 1'b0;
   logic sync_write_done = 1'b0;
   logic select_write = 1'b0;
   edo_sel_t select_data = 4'h0;
   logic clear_write = 1'b0;
   logic [7:0] clear_data = 8'h00;
   logic pin_level;
   logic prev_level = 1'b1;
   logic event_pin_out;
   logic event_pin_oe_n;
   edo_sel_t event_source_select;
   edo_sel_t code;
   int cyc = 0;
   int num_errors = 0;
   int compares = 0;
   edo_note_s notes[$];
   edo_note_s note;

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   edo_event_output #(
      .P_CYC_BOOT(`EDO_CNT_W'(C_BOOT)),
      .P_CYC_RW_ON(`EDO_CNT_W'(C_RW_ON)),
      .P_CYC_WR_OFF(`EDO_CNT_W'(C_WR_OFF)),
      .P_CYC_RD_OFF(`EDO_CNT_W'(C_RD_OFF)),
      .P_CYC_ANY_OFF(`EDO_CNT_W'(C_ANY_OFF))
   ) dut (
      .clk(clk), .reset(reset), .supply_present(supply_present), .rf_field_present(rf_field_present),
      .standby_active(standby_active), .frame_sof(frame_sof), .frame_eof(frame_eof),
      .cmd_is_write(cmd_is_write), .cmd_is_read(cmd_is_read), .response_end(response_end),
      .sync_read_last_byte(sync_read_last_byte), .sync_write_done(sync_write_done),
      .select_write(select_write), .select_data(select_data), .clear_write(clear_write),
      .clear_data(clear_data), .event_pin_in(pin_level), .event_pin_out(event_pin_out),
      .event_pin_oe_n(event_pin_oe_n), .event_source_select(event_source_select)
   );

   edo_pin_model pin (.pin_out(event_pin_out), .pin_oe_n(event_pin_oe_n), .pin_level(pin_level));

   // ***************************************
   // tasks
   // ***************************************
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
      end
   endtask

   task automatic finish_test;
      $display("compares %0d errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic expect_edge(input logic lvl, input int delay);
      edo_note_s n;
      n.lvl = lvl;
      n.at = cyc + delay;
      notes.push_back(n);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic set_sel(input edo_sel_t c);
      @(posedge clk);
      select_write <= 1'b1;
      select_data <= c;
      @(posedge clk);
      select_write <= 1'b0;
   endtask

   task automatic pulse(input int which, input logic [7:0] data);
      @(posedge clk);
      case (which)
         P_SOF: frame_sof <= 1'b1;
         P_EOF: frame_eof <= 1'b1;
         P_RESP: response_end <= 1'b1;
         P_SRD: sync_read_last_byte <= 1'b1;
         P_SWR: sync_write_done <= 1'b1;
         default: clear_write <= 1'b1;
      endcase
      clear_data <= data;
      @(posedge clk);
      {frame_sof, frame_eof, response_end, sync_read_last_byte, sync_write_done, clear_write} <= 6'h00;
   endtask

   // ***************************************
   // monitor: each pin edge takes the oldest note
   // ***************************************
   always @(posedge clk) begin
      cyc <= cyc + 1;
      prev_level <= pin_level;
      if (cyc == C_LIMIT) begin
         num_errors++;
         finish_test();
      end else if (!reset && pin_level !== prev_level) begin
         if (notes.size() == 0) begin
            check("unexpected pin edge", pin_level, prev_level);
         end else begin
            note = notes.pop_front();
            check("pin level", pin_level, note.lvl);
            check("pin edge time", (cyc - note.at <= C_TOL) && (note.at - cyc <= C_TOL), 1'b1);
         end
      end
   end

   // ***************************************
   // stimulus
   // ***************************************
   initial begin
      void'($urandom(32'h9009b5a0));
      idle(16);
      reset <= 1'b0;
      idle(3);
      check("oe_n after reset", event_pin_oe_n, 1'b1);
      check("select after reset", event_source_select, 4'h0);
      // standby source: boot delay, standby level, supply loss
      set_sel(EDO_SEL_STANDBY);
      idle(3);
      check("select readback", event_source_select, 4'h7);
      expect_edge(1'b0, C_BOOT + 5);
      supply_present <= 1'b1;
      idle(C_BOOT + 12);
      expect_edge(1'b1, 3);
      standby_active <= 1'b1;
      idle(10);
      expect_edge(1'b0, 3);
      standby_active <= 1'b0;
      idle(10);
      expect_edge(1'b1, 5);
      supply_present <= 1'b0;
      rf_field_present <= 1'b1;
      idle(10);
      // write then read indication; wrong qualifier must stay quiet
      for (int k = 0; k < 2; k++) begin
         set_sel(k ? EDO_SEL_READ : EDO_SEL_WRITE);
         cmd_is_write <= (k == 1);
         cmd_is_read <= (k == 0);
         pulse(P_SOF, 8'h00);
         idle(C_RW_ON + 10);
         cmd_is_write <= (k == 0);
         cmd_is_read <= (k == 1);
         expect_edge(1'b0, C_RW_ON + 3);
         expect_edge(1'b1, C_RW_ON + (k ? C_RD_OFF : C_WR_OFF) + 3);
         pulse(P_SOF, 8'h00);
         idle(C_RW_ON + C_WR_OFF + 10);
         expect_edge(1'b0, C_RW_ON + 3);
         pulse(P_SOF, 8'h00);
         idle(C_RW_ON + 10);
         expect_edge(1'b1, k ? 4 : 6);
         if (k) begin
            pulse(P_RESP, 8'h00);
         end else begin
            rf_field_present <= 1'b0;
         end
         idle(10);
         rf_field_present <= 1'b1;
         idle(5);
      end
      // any command
      set_sel(EDO_SEL_ANY);
      idle(5);
      expect_edge(1'b0, C_ANY_ON + 3);
      pulse(P_SOF, 8'h00);
      idle(C_ANY_ON + 10);
      expect_edge(1'b1, C_ANY_OFF + 3);
      pulse(P_EOF, 8'h00);
      idle(C_ANY_OFF + 10);
      // sync block read and write events, held until field loss or clear
      for (int k = 0; k < 2; k++) begin
         set_sel(k ? EDO_SEL_SYNC_WR : EDO_SEL_SYNC_RD);
         idle(5);
         expect_edge(1'b0, 4);
         pulse(k ? P_SWR : P_SRD, 8'h00);
         idle(10);
         pulse(P_CLR, 8'($urandom) & 8'hFE);
         idle(10);
         expect_edge(1'b1, k ? 6 : 4);
         if (k) begin
            rf_field_present <= 1'b0;
         end else begin
            pulse(P_CLR, 8'h01);
         end
         idle(10);
         rf_field_present <= 1'b1;
         idle(5);
      end
      // software event ignores field loss, only the clear ends it
      expect_edge(1'b0, 4);
      set_sel(EDO_SEL_SOFT);
      idle(10);
      rf_field_present <= 1'b0;
      idle(20);
      rf_field_present <= 1'b1;
      expect_edge(1'b1, 4);
      pulse(P_CLR, 8'h01);
      idle(10);
      expect_edge(1'b0, 4);
      set_sel(EDO_SEL_SOFT);
      idle(10);
      expect_edge(1'b1, 4);
      set_sel(4'hF);
      idle(5);
      pulse(P_CLR, 8'h01);
      // undefined codes keep the pin released whatever happens
      cmd_is_read <= 1'b1;
      for (int k = 0; k < 10; k++) begin
         code = 4'($urandom_range(0, 8));
         if (code > 4'h6) begin
            code = code + 4'h7;
         end
         set_sel(code);
         idle(3);
         check("undefined select readback", event_source_select, code);
         pulse(P_SRD, 8'h00);
         pulse(P_SWR, 8'h00);
         pulse(P_SOF, 8'h00);
         idle($urandom_range(5, 20));
      end
      idle(C_ANY_ON + 50);
      check("notes left", notes.size(), 0);
      finish_test();
   end
endmodule
